// [hw/dbx_exc_unit.sv]
// Debug registers, breakpoint match and exception arbitration of the core.
// Assumes core events arrive on aclk, AXI4-Lite master on the same clock.
`include "dbx_params.svh"
module dbx_exc_unit (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [5:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [5:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Core side
   input wire dbx_pkg::dbx_core_in_t core_i,
   output dbx_pkg::dbx_core_out_t core_o
);
   import dbx_pkg::*;

   logic [31:0] bp_q [4];
   logic [31:0] dsr_q, dcr_q, xcr_q, simd_q;
   logic [3:0] aw_idx_q;
   logic aw_have_q, w_have_q;
   logic [31:0] wdat_q;
   logic [3:0] wstb_q;
   logic [4:0] pend_q;
   logic [7:0] vec_q [5];
   logic [31:0] ip_q [5];
   logic [7:0] last_vec_q;
   dbx_core_out_t out_q;
   logic de, machine_check_enable, do_wr, do_rd;
   logic [3:0] ar_idx, wr_eff, rd_eff;
   logic wr_alias_bad, rd_alias_bad, xcr_bad;
   logic [31:0] wmask, wval;
   logic [3:0] bp_hit;
   logic [4:0] set_c, sel;
   logic [7:0] set_vec [5];
   logic [31:0] set_ip [5];
   logic div_err, ud_bus, gp_bus;

   assign de = xcr_q[`DBX_XCR_DE];
   assign machine_check_enable = xcr_q[`DBX_XCR_MCE];
   assign core_o = out_q;
   assign ar_idx = araddr[5:2];

   // [RULE7] slot aliasing
   function automatic logic [3:0] dbx_alias(input logic [3:0] idx);
      dbx_alias = idx;
      if (idx == `DBX_IDX_ALIAS_A) dbx_alias = `DBX_IDX_DSR;
      if (idx == `DBX_IDX_ALIAS_B) dbx_alias = `DBX_IDX_DCR;
   endfunction : dbx_alias

   // Byte lanes expand to a word mask
   assign wmask = {{8{wstb_q[3]}}, {8{wstb_q[2]}}, {8{wstb_q[1]}},
                   {8{wstb_q[0]}}};

   // Write decode once both halves are latched
   always_comb begin
      do_wr = aw_have_q && w_have_q && !bvalid;
      wr_eff = dbx_alias(aw_idx_q);
      // [RULE8] trap when extensions on
      wr_alias_bad = de && (aw_idx_q == `DBX_IDX_ALIAS_A ||
                            aw_idx_q == `DBX_IDX_ALIAS_B);
      // [RULE12] reserved ones refused
      xcr_bad = (aw_idx_q == `DBX_IDX_XCR) &&
                ((wdat_q & wmask & ~`DBX_XCR_WMASK) != `DBX_ZERO_RST);
      wval = wdat_q & wmask;
   end

   // AXI write address and data capture, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_idx_q <= 4'h0;
         wdat_q <= `DBX_ZERO_RST;
         wstb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_idx_q <= awaddr[5:2];
         end else if (do_wr) aw_have_q <= 1'b0;
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wdat_q <= wdata;
            wstb_q <= wstrb;
         end else if (do_wr) w_have_q <= 1'b0;
      end
   end

   // Ready only while the holding slot is free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         awready <= !aw_have_q && !(awvalid && awready) && !bvalid;
         wready <= !w_have_q && !(wvalid && wready) && !bvalid;
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `DBX_RESP_OK;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         if (aw_idx_q > `DBX_IDX_PDB) bresp <= `DBX_RESP_DEC;
         else if (wr_alias_bad || xcr_bad) bresp <= `DBX_RESP_SLV;
         else bresp <= `DBX_RESP_OK;
      end else if (bready) bvalid <= 1'b0;
   end

   // Breakpoint address registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 4; i++) bp_q[i] <= `DBX_ZERO_RST;
      end else if (do_wr && aw_idx_q <= `DBX_IDX_BP_LAST) begin
         bp_q[aw_idx_q[1:0]] <= (bp_q[aw_idx_q[1:0]] & ~wmask) | wval;
      end
   end

   // Breakpoint match, one comparator per slot
   for (genvar g = 0; g < 4; g++) begin : g_bp
      logic [1:0] ty;
      logic kind_ok;
      assign ty = dcr_q[`DBX_DCR_TYPE + 4*g +: 2];
      always_comb begin
         case (ty)
            // [RULE4] exec, write, data
            2'b00: kind_ok = core_i.acc_kind == DBX_ACC_EXEC;
            2'b01: kind_ok = core_i.acc_kind == DBX_ACC_WR;
            2'b11: kind_ok = core_i.acc_kind == DBX_ACC_RD ||
                             core_i.acc_kind == DBX_ACC_WR;
            // [RULE5] I/O only when enabled
            2'b10: kind_ok = de && (core_i.acc_kind == DBX_ACC_IORD ||
                                    core_i.acc_kind == DBX_ACC_IOWR);
            default: kind_ok = 1'b0;
         endcase
      end
      assign bp_hit[g] = core_i.acc_valid && (dcr_q[2*g +: 2] != 2'b00) &&
                         core_i.acc_addr == bp_q[g] && kind_ok;
   end

   // Status: hardware hit bits win over a clearing write
   always_ff @(posedge aclk) begin
      if (!aresetn) dsr_q <= `DBX_ZERO_RST;
      else begin
         // [RULE3] bit 12 outside write mask
         if (do_wr && !wr_alias_bad && wr_eff == `DBX_IDX_DSR)
            dsr_q <= ((dsr_q & ~wmask) | wval) & `DBX_DSR_WMASK |
                     {28'h000_0000, bp_hit};
         else dsr_q <= dsr_q | {28'h000_0000, bp_hit};
      end
   end

   // Control register
   always_ff @(posedge aclk) begin
      if (!aresetn) dcr_q <= `DBX_ZERO_RST;
      // [RULE6] reserved bits forced low
      else if (do_wr && !wr_alias_bad && wr_eff == `DBX_IDX_DCR)
         dcr_q <= ((dcr_q & ~wmask) | wval) & `DBX_DCR_WMASK;
   end

   // Extended control: write blocked whole if any reserved bit is one
   always_ff @(posedge aclk) begin
      // [RULE21] zero after reset
      if (!aresetn) xcr_q <= `DBX_ZERO_RST;
      else if (do_wr && aw_idx_q == `DBX_IDX_XCR && !xcr_bad)
         xcr_q <= ((xcr_q & ~wmask) | wval) & `DBX_XCR_WMASK;
   end

   // SIMD cause flags, sticky; a new cause beats a clear
   always_ff @(posedge aclk) begin
      if (!aresetn) simd_q <= `DBX_ZERO_RST;
      else begin
         // [RULE10] record cause
         if (do_wr && aw_idx_q == `DBX_IDX_SIMD)
            simd_q <= ((simd_q & ~wmask) | wval) & `DBX_SIMD_WMASK |
                      {26'h000_0000, core_i.simd_cause & {6{core_i.simd_err}}};
         else if (core_i.simd_err)
            simd_q <= simd_q | {26'h000_0000, core_i.simd_cause};
      end
   end

   // AXI read: one outstanding, answer one cycle after address
   always_comb begin
      do_rd = arvalid && arready;
      rd_eff = dbx_alias(ar_idx);
      rd_alias_bad = de && (ar_idx == `DBX_IDX_ALIAS_A ||
                            ar_idx == `DBX_IDX_ALIAS_B);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= `DBX_ZERO_RST;
         rresp <= `DBX_RESP_OK;
      end else begin
         arready <= !rvalid && !do_rd;
         if (do_rd) begin
            rvalid <= 1'b1;
            rresp <= rd_alias_bad ? `DBX_RESP_SLV : `DBX_RESP_OK;
            rdata <= `DBX_ZERO_RST;
            if (!rd_alias_bad) begin
               case (rd_eff)
                  4'h0, 4'h1, 4'h2, 4'h3: rdata <= bp_q[rd_eff[1:0]];
                  `DBX_IDX_DSR: rdata <= dsr_q;
                  `DBX_IDX_DCR: rdata <= dcr_q;
                  `DBX_IDX_XCR: rdata <= xcr_q;
                  `DBX_IDX_SIMD: rdata <= simd_q;
                  `DBX_IDX_EXC: rdata <= {19'h0_0000, pend_q, last_vec_q};
                  `DBX_IDX_PDB: rdata <= out_q.page_dir_base;
                  default: rresp <= `DBX_RESP_DEC;
               endcase
            end
         end else if (rready) rvalid <= 1'b0;
      end
   end

   // Divide check, signed quotient range of the operand size
   always_comb begin
      // [RULE16] most negative quotient allowed
      if (core_i.div_word)
         div_err = $signed(core_i.div_quot) < -32'sd32768 ||
                   $signed(core_i.div_quot) > 32'sd32767;
      else
         div_err = $signed(core_i.div_quot) < -32'sd128 ||
                   $signed(core_i.div_quot) > 32'sd127;
      div_err = core_i.div_valid && (div_err || core_i.div_zero);
   end

   assign ud_bus = (do_wr && wr_alias_bad) || (do_rd && rd_alias_bad);
   assign gp_bus = do_wr && xcr_bad;

   // Event sources per category, first match inside a category wins
   always_comb begin
      for (int c = 0; c < 5; c++) begin
         set_c[c] = 1'b0;
         set_vec[c] = `DBX_VEC_DE;
         set_ip[c] = core_i.cur_ip;
      end
      // Category 0: debug trap, resumes after the instruction
      set_c[0] = |bp_hit;
      set_vec[0] = `DBX_VEC_DB;
      set_ip[0] = core_i.next_ip;
      // [RULE22] boundary sampling only
      set_c[1] = core_i.int_req && core_i.boundary;
      set_vec[1] = core_i.int_vec;
      set_ip[1] = core_i.next_ip;
      // [RULE13] fetch-side reserved bit
      set_c[2] = core_i.fetch_pte_rsvd;
      set_vec[2] = `DBX_VEC_PF;
      // Category 3: decode faults
      if (core_i.dec_valid) begin
         set_c[3] = 1'b1;
         // [RULE18] length limit
         if (core_i.dec_len > `DBX_MAX_LEN) set_vec[3] = `DBX_VEC_GP;
         // [RULE17] bad lock prefix
         else if (core_i.dec_lock_bad) set_vec[3] = `DBX_VEC_UD;
         // [RULE9] test register move
         else if (core_i.dec_test_mov) set_vec[3] = `DBX_VEC_UD;
         else set_c[3] = 1'b0;
      end
      // Category 4: execution faults keep the faulting pointer
      set_c[4] = 1'b1;
      // [RULE15] faulting divide pointer
      if (div_err) set_vec[4] = `DBX_VEC_DE;
      else if (core_i.data_pte_rsvd) set_vec[4] = `DBX_VEC_PF;
      // [RULE14] alignment check
      else if (core_i.unaligned && core_i.align_active)
         set_vec[4] = `DBX_VEC_AC;
      // [RULE10] SIMD vector
      else if (core_i.simd_err) set_vec[4] = `DBX_VEC_XF;
      // [RULE11] gated by enable
      else if (core_i.mc_err && machine_check_enable) set_vec[4] = `DBX_VEC_MC;
      else if (gp_bus) set_vec[4] = `DBX_VEC_GP;
      else if (ud_bus) set_vec[4] = `DBX_VEC_UD;
      else set_c[4] = 1'b0;
   end

   // [RULE19] lowest category index first
   always_comb begin
      sel = 5'b0_0000;
      if (core_i.boundary) begin
         for (int c = 4; c >= 0; c--) begin
            if (pend_q[c]) sel = 5'b0_0001 << c;
         end
      end
   end

   // Pending slots; a new event beats the delivery clear
   for (genvar c = 0; c < 5; c++) begin : g_cat
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pend_q[c] <= 1'b0;
            vec_q[c] <= 8'h00;
            ip_q[c] <= `DBX_ZERO_RST;
         // [RULE23] held until served
         end else if (set_c[c] && (!pend_q[c] || sel[c])) begin
            pend_q[c] <= 1'b1;
            vec_q[c] <= set_vec[c];
            ip_q[c] <= set_ip[c];
         end else if (sel[c]) pend_q[c] <= 1'b0;
      end
   end

   // Delivery to the core, one event per boundary
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q.exc_valid <= 1'b0;
         out_q.exc_vector <= 8'h00;
         out_q.exc_ret_ip <= `DBX_ZERO_RST;
         last_vec_q <= 8'h00;
      end else begin
         out_q.exc_valid <= |sel;
         for (int c = 0; c < 5; c++) begin
            if (sel[c]) begin
               out_q.exc_vector <= vec_q[c];
               out_q.exc_ret_ip <= ip_q[c];
               last_vec_q <= vec_q[c];
            end
         end
      end
   end

   // Descriptor load checks, one-cycle pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q.rmw_req <= 1'b0;
         out_q.desc_invalid <= 1'b0;
      end else begin
         // [RULE1] invalid rights bytes
         out_q.desc_invalid <= core_i.desc_load &&
            (core_i.desc_ar == `DBX_AR_BAD0 || core_i.desc_ar == `DBX_AR_BAD1);
         // [RULE2] RMW only if clear
         out_q.rmw_req <= core_i.desc_load && !core_i.desc_accessed;
      end
   end

   // Page directory base follows only 32-bit task state
   always_ff @(posedge aclk) begin
      if (!aresetn) out_q.page_dir_base <= `DBX_ZERO_RST;
      // [RULE20] 16-bit format keeps base
      else if (core_i.ts_valid && core_i.ts_32)
         out_q.page_dir_base <= core_i.ts_pdb;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_desc_rmw;
      core_i.desc_load && !core_i.desc_accessed |=> out_q.rmw_req;
   endproperty
   a_desc_rmw: assert property (p_desc_rmw) // [RULE2]
      else $error("accessed bit clear but no locked update");

   property p_desc_bad;
      core_i.desc_load && core_i.desc_ar == 8'h80 |=> out_q.desc_invalid;
   endproperty
   a_desc_bad: assert property (p_desc_bad) // [RULE1]
      else $error("invalid rights byte not flagged");

   property p_dsr_b12;
      do_wr && wr_eff == `DBX_IDX_DSR |=> !dsr_q[12];
   endproperty
   a_dsr_b12: assert property (p_dsr_b12) // [RULE3]
      else $error("status bit 12 took a write");

   property p_dcr_rsvd;
      do_wr |=> (dcr_q & 32'h0000_D800) == 32'h0000_0000;
   endproperty
   a_dcr_rsvd: assert property (p_dcr_rsvd) // [RULE6]
      else $error("control reserved bit set");

   property p_alias_ud;
      do_wr && wr_alias_bad |=> bvalid && bresp == 2'b10 ##1 pend_q[4];
   endproperty
   a_alias_ud: assert property (p_alias_ud) // [RULE8]
      else $error("slot access with extensions on did not fault");

   property p_mc_gate;
      out_q.exc_valid && out_q.exc_vector == 8'h12 |-> $past(machine_check_enable, 2);
   endproperty
   a_mc_gate: assert property (p_mc_gate) // [RULE11]
      else $error("machine check delivered while disabled");

   property p_len_gp;
      core_i.dec_valid && core_i.dec_len > 5'd15 && !pend_q[3]
         |=> pend_q[3] && vec_q[3] == 8'h0D;
   endproperty
   a_len_gp: assert property (p_len_gp) // [RULE18]
      else $error("overlong instruction not faulted");

   // A new lower event may arrive meanwhile; only a lost one is an error
   property p_trap_first;
      core_i.boundary && pend_q[0] |=> out_q.exc_valid &&
         out_q.exc_vector == 8'h01 &&
         ($past(pend_q[4:1]) & ~pend_q[4:1]) == 4'h0;
   endproperty
   a_trap_first: assert property (p_trap_first) // [RULE19]
      else $error("trap not served first");

   property p_pdb_keep;
      core_i.ts_valid && !core_i.ts_32 |=> $stable(out_q.page_dir_base);
   endproperty
   a_pdb_keep: assert property (p_pdb_keep) // [RULE20]
      else $error("16-bit task switch changed page base");

endmodule : dbx_exc_unit

// [shared/dbx_params.svh]
// Constants of the debug and exception unit: offsets, masks, vectors.
// Assumes it is included once per compile unit by the package and design.
// Operation
// [RULE1] Access-rights bytes 80H and 00H mark a loaded descriptor invalid.
// [RULE2] Descriptor load sets accessed bit by locked RMW only if clear.
// [RULE3] Status bit 12 ignores software writes and keeps its fixed value.
// [RULE4] Breakpoint type 00 exec, 01 data write, 11 data read or write.
// [RULE5] Type 10 matches I/O read or write only with extensions enabled.
// [RULE6] Control bits 11, 12, 14 and 15 always read zero.
// [RULE7] Extensions off: slots 4 and 5 alias status and control.
// [RULE8] Extensions on: access to slot 4 or 5 raises invalid opcode.
// [RULE9] Moves to or from legacy test registers raise invalid opcode.
// [RULE10] SIMD floating-point errors go to vector 19, cause kept in register.
// [RULE11] Machine check vector 18 only while enable flag set; clear at reset.
// [RULE12] Writing one to a reserved special-register bit is blocked, vector 13.
// [RULE13] Reserved bit set in a paging entry raises page fault, vector 14.
// [RULE14] Unaligned reference with alignment checking raises vector 17.
// [RULE15] Divide error, vector 0, returns to the faulting divide itself.
// [RULE16] Signed quotient equal to most negative value is no divide error.
// [RULE17] Lock prefix on a non-lockable instruction raises vector 6.
// [RULE18] Instruction longer than 15 bytes raises general protection.
// [RULE19] Order: traps, interrupts, fetch faults, decode faults, exec faults.
// [RULE20] Switch to a 16-bit task state keeps the page directory base.
// [RULE21] Extensions flag cleared by reset; extended control reads zero.
// [RULE22] Interrupts taken only at boundaries; return points at next insn.
// [RULE23] Lower pending events are held and served later, never lost.
`ifndef DBX_PARAMS_SVH
`define DBX_PARAMS_SVH
// Register word indices (byte address is index times four)
`define DBX_IDX_BP_LAST 4'h3
`define DBX_IDX_ALIAS_A 4'h4
`define DBX_IDX_ALIAS_B 4'h5
`define DBX_IDX_DSR 4'h6
`define DBX_IDX_DCR 4'h7
`define DBX_IDX_XCR 4'h8
`define DBX_IDX_SIMD 4'h9
`define DBX_IDX_EXC 4'hA
`define DBX_IDX_PDB 4'hB
// Writable masks and reset values
`define DBX_DSR_WMASK 32'h0000_E00F
`define DBX_DCR_WMASK 32'hFFFF_27FF
`define DBX_XCR_WMASK 32'h0000_0048
`define DBX_SIMD_WMASK 32'h0000_003F
`define DBX_ZERO_RST 32'h0000_0000
// Field positions
`define DBX_XCR_DE 3
`define DBX_XCR_MCE 6
`define DBX_DCR_TYPE 16
// Vectors and limits
`define DBX_VEC_DE 8'h00
`define DBX_VEC_DB 8'h01
`define DBX_VEC_UD 8'h06
`define DBX_VEC_GP 8'h0D
`define DBX_VEC_PF 8'h0E
`define DBX_VEC_AC 8'h11
`define DBX_VEC_MC 8'h12
`define DBX_VEC_XF 8'h13
`define DBX_AR_BAD0 8'h80
`define DBX_AR_BAD1 8'h00
`define DBX_MAX_LEN 5'd15
`define DBX_RESP_OK 2'b00
`define DBX_RESP_SLV 2'b10
`define DBX_RESP_DEC 2'b11
`endif

// [shared/dbx_pkg.sv]
// Types of the debug and exception unit.
// Assumes dbx_params.svh sits on the include path.
`include "dbx_params.svh"
package dbx_pkg;
   typedef enum logic [2:0] {
      DBX_ACC_EXEC, DBX_ACC_RD, DBX_ACC_WR, DBX_ACC_IORD, DBX_ACC_IOWR
   } dbx_acc_t;
   typedef struct packed {
      logic boundary;
      logic [31:0] cur_ip;
      logic [31:0] next_ip;
      logic acc_valid;
      dbx_acc_t acc_kind;
      logic [31:0] acc_addr;
      logic desc_load;
      logic [7:0] desc_ar;
      logic desc_accessed;
      logic int_req;
      logic [7:0] int_vec;
      logic fetch_pte_rsvd;
      logic dec_valid;
      logic [4:0] dec_len;
      logic dec_lock_bad;
      logic dec_test_mov;
      logic div_valid;
      logic div_word;
      logic div_zero;
      logic [31:0] div_quot;
      logic data_pte_rsvd;
      logic unaligned;
      logic align_active;
      logic simd_err;
      logic [5:0] simd_cause;
      logic mc_err;
      logic ts_valid;
      logic ts_32;
      logic [31:0] ts_pdb;
   } dbx_core_in_t;
   typedef struct packed {
      logic exc_valid;
      logic [7:0] exc_vector;
      logic [31:0] exc_ret_ip;
      logic rmw_req;
      logic desc_invalid;
      logic [31:0] page_dir_base;
   } dbx_core_out_t;
endpackage : dbx_pkg

// [sim/test_debug_exception_logic.sv]
// Bench for the debug and exception unit: bus and core-event scenarios.
// Assumes dbx_pkg and dbx_params.svh are compiled first; one aclk domain.
`include "dbx_params.svh"
module test_debug_exception_logic;
   timeunit 1ns;
   timeprecision 1ps;
   import dbx_pkg::*;
   localparam logic [1:0] rok = `DBX_RESP_OK;
   localparam logic [1:0] rslv = `DBX_RESP_SLV;
   localparam logic [1:0] rdec = `DBX_RESP_DEC;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   dbx_core_in_t ci, base, e;
   dbx_core_out_t co;
   int err_count, check_count, i;
   logic [7:0] vt [9];
   logic [1:0] bt [8];
   dbx_acc_t bk [8];
   logic bh [8];

   dbx_exc_unit u_dbx_exc_unit (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .core_i(ci), .core_o(co)
   );

   // Compare and count; unknowns never match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // A spent wait bound is scored and ends the run
   task automatic tmo(input int n);
      if (n >= 64) begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end
   endtask : tmo

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [3:0] idx, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 64 && !(a && w); n++) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      tmo(n);
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!bvalid && n < 64);
      tmo(n);
      chk(bresp, er);
      bready <= 1'b0;
   endtask : wr

   // Read; data compared only when an OKAY answer is expected
   task automatic rd(input logic [3:0] idx, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!arready && n < 64);
      tmo(n);
      arvalid <= 1'b0;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!rvalid && n < 64);
      tmo(n);
      chk(rresp, er);
      if (er == rok) begin
         chk(rdata, ed);
      end
      rready <= 1'b0;
   endtask : rd

   // One-cycle core event; leading edge keeps drives one per step
   task automatic pulse(input dbx_core_in_t ev);
      @(posedge aclk);
      ci <= ev;
      @(posedge aclk);
      ci <= base;
   endtask : pulse

   // One boundary cycle, then look for a delivery within four cycles
   task automatic ex(input logic hit, input logic [7:0] vec);
      logic s;
      s = 1'b0;
      @(posedge aclk);
      ci.boundary <= 1'b1;
      @(posedge aclk);
      ci <= base;
      repeat (4) begin
         @(posedge aclk);
         if (co.exc_valid === 1'b1 && !s) begin
            s = 1'b1;
            chk(co.exc_vector, vec);
         end
      end
      chk(s, hit);
   endtask : ex

   // Free-running 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Main sequence
   initial begin
      err_count = 0;
      check_count = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      base = '0;
      base.cur_ip = 32'h0000_1000;
      base.next_ip = 32'h0000_1004;
      ci = base;
      vt = '{`DBX_VEC_GP, `DBX_VEC_UD, `DBX_VEC_UD, `DBX_VEC_PF, `DBX_VEC_AC,
             `DBX_VEC_XF, `DBX_VEC_MC, `DBX_VEC_DE, `DBX_VEC_PF};
      bt = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd3, 2'd3, 2'd2, 2'd2};
      bk = '{DBX_ACC_EXEC, DBX_ACC_RD, DBX_ACC_WR, DBX_ACC_RD, DBX_ACC_RD,
             DBX_ACC_EXEC, DBX_ACC_IOWR, DBX_ACC_WR};
      bh = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(4'h8, 32'h0, rok);
      wr(4'h6, 32'hFFFF_FFFF, rok);
      rd(4'h6, 32'h0000_E00F, rok);
      wr(4'h7, 32'hFFFF_FFFF, rok);
      rd(4'h7, 32'hFFFF_27FF, rok);
      wr(4'h4, 32'h0000_2001, rok);
      rd(4'h6, 32'h0000_2001, rok);
      wr(4'h5, 32'h0, rok);
      rd(4'h7, 32'h0, rok);
      rd(4'hC, 32'h0, rdec);
      wr(4'hF, 32'h1, rdec);
      $display("test registers done");
      wr(4'h8, 32'h0000_0001, rslv);
      rd(4'h8, 32'h0, rok);
      ex(1'b1, `DBX_VEC_GP);
      wr(4'h8, 32'h0000_0008, rok);
      wr(4'h4, 32'h1, rslv);
      ex(1'b1, `DBX_VEC_UD);
      rd(4'h6, 32'h0000_2001, rok);
      $display("test blocked done");
      for (i = 0; i < 5; i++) begin
         e = base;
         e.dec_len = 5'd15;
         e.div_quot = 32'hFFFF_FF80;
         case (i)
            0: e.dec_valid = 1'b1;
            1: e.div_valid = 1'b1;
            2: begin
               e.div_valid = 1'b1;
               e.div_word = 1'b1;
               e.div_quot = 32'hFFFF_8000;
            end
            3: e.mc_err = 1'b1;
            default: e.unaligned = 1'b1;
         endcase
         pulse(e);
         ex(1'b0, 8'h00);
      end
      wr(4'h8, 32'h0000_0048, rok);
      for (i = 0; i < 9; i++) begin
         e = base;
         e.dec_valid = (i < 3);
         e.dec_len = (i == 0) ? 5'd16 : 5'd2;
         e.dec_lock_bad = (i == 1);
         e.dec_test_mov = (i == 2);
         e.data_pte_rsvd = (i == 3);
         e.unaligned = (i == 4);
         e.align_active = (i == 4);
         e.simd_err = (i == 5);
         e.simd_cause = 6'h05;
         e.mc_err = (i == 6);
         e.div_valid = (i == 7);
         e.div_zero = (i == 7);
         e.fetch_pte_rsvd = (i == 8);
         pulse(e);
         ex(1'b1, vt[i]);
         if (i == 7) begin
            chk(co.exc_ret_ip, 32'h0000_1000);
         end
      end
      rd(4'h9, 32'h0000_0005, rok);
      $display("test vectors done");
      wr(4'h0, 32'h0000_2000, rok);
      for (i = 0; i < 8; i++) begin
         wr(4'h7, {14'h0, bt[i], 16'h0001}, rok);
         wr(4'h6, 32'h0, rok);
         e = base;
         e.acc_valid = 1'b1;
         e.acc_kind = bk[i];
         e.acc_addr = 32'h0000_2000;
         pulse(e);
         rd(4'h6, {31'h0, bh[i]}, rok);
         ex(bh[i], `DBX_VEC_DB);
      end
      // competing events served in order, none lost
      wr(4'h7, 32'h0000_0001, rok);
      e.acc_kind = DBX_ACC_EXEC;
      e.dec_valid = 1'b1;
      e.dec_len = 5'd16;
      e.data_pte_rsvd = 1'b1;
      pulse(e);
      ex(1'b1, `DBX_VEC_DB);
      chk(co.exc_ret_ip, 32'h0000_1004);
      ex(1'b1, `DBX_VEC_GP);
      ex(1'b1, `DBX_VEC_PF);
      $display("test breakpoints done");
      for (i = 0; i < 4; i++) begin
         e = base;
         e.desc_load = 1'b1;
         e.desc_ar = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : 8'h93;
         e.desc_accessed = (i != 2);
         pulse(e);
         @(posedge aclk);
         chk(co.desc_invalid, i < 2);
         chk(co.rmw_req, i == 2);
      end
      // a 16-bit task state leaves the base alone
      e = base;
      e.ts_valid = 1'b1;
      e.ts_32 = 1'b1;
      e.ts_pdb = 32'h0001_2000;
      pulse(e);
      e.ts_32 = 1'b0;
      e.ts_pdb = 32'h0003_4000;
      pulse(e);
      rd(4'hB, 32'h0001_2000, rok);
      chk(co.page_dir_base, 32'h0001_2000);
      e = base;
      e.int_req = 1'b1;
      e.int_vec = 8'h40;
      @(posedge aclk);
      ci <= e;
      repeat (3) @(posedge aclk);
      chk(co.exc_valid, 1'b0);
      // Sampled at this boundary, served at the next one
      ex(1'b0, 8'h00);
      ex(1'b1, 8'h40);
      chk(co.exc_ret_ip, 32'h0000_1004);
      $display("test core events done");
      tally_and_finish();
   end
endmodule : test_debug_exception_logic
